/* File: verilog/rstisd_regs.svh */
// Constants for the reset state and in-system disable controller.
// Operation
// - Status output low during any reset
// - Status low for pin reset and warm-up
// - Watchdog reset shows exactly two machine cycles
// - Enabled oscillator failure holds reset throughout
// - Oscillator runs, execution stops in reset
// - Reset leaves RAM contents untouched
// - Every reset reloads the stack pointer
// - Reset clears interrupt enables, timer runs
// - Reset selects shortest watchdog interval
// - Port latches go FFh within two cycles
// - Fetch restarts at address zero
// - Pin reset held outside, power-on self-ends
// - Disable mode floats pins, keeps status, oscillator
// - Strobes held two cycles enter disable mode
// - Port 2 top bits sampled at release
// - Weak pullups on port 2 top bits
// - Reset pin leaves disable mode
// - Warm-up counts 65536 clocks before release
// - Watchdog reset held two machine cycles
// - Pin reset synchronised, enters within two cycles
`ifndef RSTISD_REGS_SVH
`define RSTISD_REGS_SVH
`define RSTISD_CLKS_PER_MC 4
`define RSTISD_WARM_CLKS 65536
`define RSTISD_WDT_MC 2
`define RSTISD_DIS_MC 2
`define RSTISD_PORT_RST 8'hFF
`define RSTISD_SP_RST 8'h07
`define RSTISD_FETCH_RST 16'h0000
`define RSTISD_WDT_SEL_RST 2'h0
`define RSTISD_P2_TEST_RST 3'h7
`endif

/* File: verilog/rstisd_pkg.sv */
// Types shared by the reset state and in-system disable controller.
package rstisd_pkg;
  typedef enum logic [1:0] {
    DIS_IDLE,
    DIS_QUAL,
    DIS_ON
  } rstisd_dis_state_t;
  typedef logic [7:0] rstisd_byte_t;
endpackage : rstisd_pkg

/* File: verilog/rstisd_tick_if.sv */
// Internal carrier for machine-cycle tick and warm-up handshake.
`timescale 1ns/100ps
interface rstisd_tick_if;
  logic mc_tick;
  logic warm_start;
  logic warm_busy;
  modport div (output mc_tick);
  modport warm (input warm_start, output warm_busy);
  modport core (input mc_tick, input warm_busy, output warm_start);
endinterface : rstisd_tick_if

/* File: verilog/rstisd_mc_div.sv */
// Machine-cycle enable divider.
`timescale 1ns/100ps
module rstisd_mc_div #(
  parameter int CLKS_PER_MC = 4
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  rstisd_tick_if.div tick
);
  localparam int CW = (CLKS_PER_MC > 1) ? $clog2(CLKS_PER_MC) : 1;
  localparam logic [CW-1:0] LAST = CW'(CLKS_PER_MC - 1);
  logic [CW-1:0] cnt_ff;
  logic tick_ff;
  wire wrap = (cnt_ff == LAST);

  // Free-running count; one tick pulse per machine cycle.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= wrap ? '0 : cnt_ff + 1'b1;
      tick_ff <= wrap;
    end
  end
  assign tick.mc_tick = tick_ff;
endmodule : rstisd_mc_div

/* File: verilog/rstisd_warmup.sv */
// Crystal warm-up delay counter.
`timescale 1ns/100ps
module rstisd_warmup #(
  parameter int WARM_CLKS = 65536
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  rstisd_tick_if.warm wu
);
  localparam int CW = $clog2(WARM_CLKS + 1);
  logic [CW-1:0] cnt_ff;
  logic busy_ff;

  // Reload while the start level stands, then count down to release.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= CW'(WARM_CLKS);
      busy_ff <= 1'b1;
    end else if (wu.warm_start) begin
      cnt_ff <= CW'(WARM_CLKS);
      busy_ff <= 1'b1;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
      busy_ff <= (cnt_ff != CW'(1));
    end else begin
      busy_ff <= 1'b0;
    end
  end
  assign wu.warm_busy = busy_ff;
endmodule : rstisd_warmup

/* File: verilog/rstisd_core.sv */
// Reset sequencing, reset-state register defaults and in-system disable detection.
`timescale 1ns/100ps
`include "rstisd_regs.svh"
module rstisd_core import rstisd_pkg::*; #(
  parameter int CLKS_PER_MC = `RSTISD_CLKS_PER_MC,
  parameter int WARM_CLKS = `RSTISD_WARM_CLKS
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic por_i,
  input wire logic stop_mode_i,
  input wire logic ext_rst_i,
  input wire logic wdt_timeout_i,
  input wire logic osc_fail_i,
  input wire logic osc_fail_detect_enable_i,
  input wire logic ale_i,
  input wire logic program_store_strobe_n_i,
  input wire logic [2:0] p2_top_i,
  input wire logic ram_wr_i,
  input wire logic sp_wr_i,
  input wire logic [7:0] sp_wdata_i,
  input wire logic ie_wr_i,
  input wire logic [7:0] ie_wdata_i,
  input wire logic tmr_run_wr_i,
  input wire logic [1:0] tmr_run_wdata_i,
  input wire logic wdt_sel_wr_i,
  input wire logic [1:0] wdt_sel_wdata_i,
  input wire logic port_wr_i,
  input wire logic [7:0] port_wdata_i,
  output logic reset_status_out_n_o,
  output logic core_reset_o,
  output logic exec_enable_o,
  output logic osc_enable_o,
  output logic ram_wr_en_o,
  output logic [7:0] sp_o,
  output logic [7:0] ie_o,
  output logic [1:0] tmr_run_o,
  output logic [1:0] wdt_sel_o,
  output logic [7:0] port_latch_o,
  output logic port_weak_pullup_o,
  output logic port_oe_n_o,
  output logic ctrl_pins_oe_n_o,
  output logic p2_top_pullup_o,
  output logic test_mode_o,
  output logic in_system_disable_o,
  output logic fetch_start_o,
  output logic [15:0] fetch_addr_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Machine-cycle divider and warm-up counter.

  localparam int WDT_CLKS = `RSTISD_WDT_MC * CLKS_PER_MC;
  localparam int WCW = $clog2(WDT_CLKS + 1);
  localparam logic [WCW-1:0] WDT_LOAD = WCW'(WDT_CLKS);
  localparam logic [1:0] DIS_LAST = 2'(`RSTISD_DIS_MC - 1);

  rstisd_tick_if tick_if ();

  rstisd_mc_div #(.CLKS_PER_MC(CLKS_PER_MC)) u_div (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .tick(tick_if.div)
  );

  rstisd_warmup #(.WARM_CLKS(WARM_CLKS)) u_warm (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .wu(tick_if.warm)
  );

  wire mc_tick = tick_if.mc_tick;

  // Power below threshold, or a pin reset while stopped, restarts warm-up.
  assign tick_if.warm_start = por_i | (stop_mode_i & ext_rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Reset sources.

  logic ext_q1_ff;
  logic ext_act_ff;
  logic [WCW-1:0] wdt_cnt_ff;
  logic pin_q_ff;

  // The reset pin is sampled on two machine-cycle ticks before it acts.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_q1_ff <= 1'b0;
      ext_act_ff <= 1'b0;
    end else if (mc_tick) begin
      ext_q1_ff <= ext_rst_i;
      ext_act_ff <= ext_q1_ff & ext_rst_i;
    end
  end

  // Watchdog reset lasts a fixed count of clocks equal to two machine cycles.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wdt_cnt_ff <= '0;
    end else if (wdt_timeout_i) begin
      wdt_cnt_ff <= WDT_LOAD;
    end else if (wdt_cnt_ff != '0) begin
      wdt_cnt_ff <= wdt_cnt_ff - 1'b1;
    end
  end

  // Previous level of the reset pin, for release detection.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_q_ff <= 1'b0;
    end else begin
      pin_q_ff <= ext_rst_i;
    end
  end

  wire wdt_act = (wdt_cnt_ff != '0);
  wire ofail_act = osc_fail_i & osc_fail_detect_enable_i;
  wire any_rst = tick_if.warm_busy | ext_act_ff | wdt_act | ofail_act;
  wire pin_fall = pin_q_ff & ~ext_rst_i;
  wire strobes_ok = ~ale_i & program_store_strobe_n_i;

  ////////////////////////////////////////////////////////////////////////////
  // In-system disable detection.

  rstisd_dis_state_t dis_state_ff;
  rstisd_dis_state_t nxt_dis_state;
  logic [1:0] dis_cnt_ff;
  logic [1:0] nxt_dis_cnt;

  // Qualify the strobes from reset release across two machine-cycle ticks.
  always_comb begin
    nxt_dis_state = dis_state_ff;
    nxt_dis_cnt = dis_cnt_ff;
    case (dis_state_ff)
      DIS_IDLE: begin
        nxt_dis_cnt = 2'h0;
        if (pin_fall && strobes_ok) begin
          nxt_dis_state = DIS_QUAL;
        end
      end
      DIS_QUAL: begin
        if (ext_rst_i || !strobes_ok) begin
          nxt_dis_state = DIS_IDLE;
        end else if (mc_tick) begin
          nxt_dis_cnt = dis_cnt_ff + 2'h1;
          if (dis_cnt_ff == DIS_LAST) begin
            nxt_dis_state = DIS_ON;
          end
        end
      end
      DIS_ON: begin
        if (ext_rst_i) begin
          nxt_dis_state = DIS_IDLE;
        end
      end
      default: begin
        nxt_dis_state = DIS_IDLE;
      end
    endcase
  end

  // State register for the disable sequence.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dis_state_ff <= DIS_IDLE;
      dis_cnt_ff <= 2'h0;
    end else begin
      dis_state_ff <= nxt_dis_state;
      dis_cnt_ff <= nxt_dis_cnt;
    end
  end

  wire dis_on = (nxt_dis_state == DIS_ON);

  ////////////////////////////////////////////////////////////////////////////
  // Reset status, execution control and pin drive.

  // Status pin keeps being driven even in disable mode.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_status_out_n_o <= 1'b0;
      core_reset_o <= 1'b1;
      exec_enable_o <= 1'b0;
      osc_enable_o <= 1'b1;
    end else begin
      reset_status_out_n_o <= ~any_rst;
      core_reset_o <= any_rst;
      exec_enable_o <= ~any_rst & ~dis_on;
      osc_enable_o <= 1'b1;
    end
  end

  // Ports and control pins float in disable mode; top port 2 bits pull up in reset.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_oe_n_o <= 1'b1;
      ctrl_pins_oe_n_o <= 1'b1;
      port_weak_pullup_o <= 1'b1;
      p2_top_pullup_o <= 1'b1;
      in_system_disable_o <= 1'b0;
    end else begin
      port_oe_n_o <= dis_on;
      ctrl_pins_oe_n_o <= dis_on | any_rst | ext_rst_i;
      port_weak_pullup_o <= ~dis_on;
      p2_top_pullup_o <= (any_rst | ext_rst_i) & ~dis_on;
      in_system_disable_o <= dis_on;
    end
  end

  // Test mode is latched only at release of the reset pin.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      test_mode_o <= 1'b0;
    end else if (pin_fall) begin
      test_mode_o <= (p2_top_i != `RSTISD_P2_TEST_RST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state reinitialised by every reset.

  wire rst_busy = any_rst | ext_rst_i;

  // Stack pointer, interrupt enables, timer runs and watchdog interval.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sp_o <= `RSTISD_SP_RST;
      ie_o <= 8'h00;
      tmr_run_o <= 2'h0;
      wdt_sel_o <= `RSTISD_WDT_SEL_RST;
    end else if (any_rst) begin
      sp_o <= `RSTISD_SP_RST;
      ie_o <= 8'h00;
      tmr_run_o <= 2'h0;
      wdt_sel_o <= `RSTISD_WDT_SEL_RST;
    end else begin
      if (sp_wr_i) begin
        sp_o <= sp_wdata_i;
      end
      if (ie_wr_i) begin
        ie_o <= ie_wdata_i;
      end
      if (tmr_run_wr_i) begin
        tmr_run_o <= tmr_run_wdata_i;
      end
      if (wdt_sel_wr_i) begin
        wdt_sel_o <= wdt_sel_wdata_i;
      end
    end
  end

  // Port latch goes high as soon as the pin or any internal source asks.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_latch_o <= `RSTISD_PORT_RST;
    end else if (rst_busy) begin
      port_latch_o <= `RSTISD_PORT_RST;
    end else if (port_wr_i) begin
      port_latch_o <= port_wdata_i;
    end
  end

  // RAM writes are only blocked; reset never clears memory.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ram_wr_en_o <= 1'b0;
    end else begin
      ram_wr_en_o <= ram_wr_i & ~any_rst & ~dis_on;
    end
  end

  // One pulse at the end of reset restarts fetch at address zero.
  logic rst_q_ff;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q_ff <= 1'b1;
      fetch_start_o <= 1'b0;
      fetch_addr_o <= `RSTISD_FETCH_RST;
    end else begin
      rst_q_ff <= any_rst;
      fetch_start_o <= rst_q_ff & ~any_rst;
      if (any_rst) begin
        fetch_addr_o <= `RSTISD_FETCH_RST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  // Watchdog reset starts with its counter loaded to the full two-cycle count.
  wdt_pulse_len_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(wdt_act) && !tick_if.warm_busy && !ext_act_ff && !ofail_act && !wdt_timeout_i
      |-> wdt_cnt_ff == WDT_LOAD)
    else $error("watchdog reset count not loaded");

  wdt_hold_cnt_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wdt_timeout_i |=> wdt_act [*8])
    else $error("watchdog reset shorter than expected");

  status_follows_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    any_rst |=> !reset_status_out_n_o && core_reset_o)
    else $error("status output not low in reset");

  ofail_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (osc_fail_i && osc_fail_detect_enable_i) [*2] |-> !reset_status_out_n_o)
    else $error("oscillator failure did not hold reset");

  pin_enter_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ext_rst_i [*8] |=> ext_act_ff ##1 !reset_status_out_n_o)
    else $error("pin reset not entered in time");

  port_high_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(ext_rst_i) |=> port_latch_o == `RSTISD_PORT_RST)
    else $error("port latch not set on reset");

  regs_cleared_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    any_rst |=> ie_o == 8'h00 && tmr_run_o == 2'h0 && sp_o == `RSTISD_SP_RST && wdt_sel_o == 2'h0)
    else $error("register state not reinitialised");

  dis_exit_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    in_system_disable_o && ext_rst_i |=> !in_system_disable_o)
    else $error("reset pin did not leave disable mode");

  dis_float_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    in_system_disable_o |-> port_oe_n_o && ctrl_pins_oe_n_o && osc_enable_o)
    else $error("pins driven in disable mode");

  fetch_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    fetch_start_o |-> fetch_addr_o == `RSTISD_FETCH_RST && $past(core_reset_o))
    else $error("fetch did not restart at zero");

  // Watchdog reset ends after its count when no new time-out arrives.
  wdt_pulse_end_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wdt_timeout_i ##1 !wdt_timeout_i [*8] |=> !wdt_act)
    else $error("watchdog reset longer than two machine cycles");

  dis_keep_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    in_system_disable_o && !ext_rst_i |=> in_system_disable_o)
    else $error("disable mode left without reset pin");

  p2_pullup_rst_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ext_rst_i && !in_system_disable_o |=> p2_top_pullup_o)
    else $error("port 2 top pullups off in reset");

  test_mode_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !pin_fall |=> $stable(test_mode_o))
    else $error("test mode changed outside reset release");

endmodule : rstisd_core

/* File: dv/rstisd_board.sv */
// Board model driving the reset pin, strobe pins and port 2 top bits.
`timescale 1ns/100ps
module rstisd_board (
  input wire logic mclk_i,
  input wire logic p2_pullup_i,
  output logic ext_rst_o,
  output logic ale_o,
  output logic program_store_strobe_n_o,
  output logic [2:0] p2_top_o
);
  logic hold_ff, p2_low_ff;
  logic [2:0] float_ff;
  // Start with every line released.
  initial begin
    ext_rst_o = 1'b0;
    hold_ff = 1'b0;
    p2_low_ff = 1'b0;
    float_ff = 3'h5;
    ale_o = 1'b0;
    program_store_strobe_n_o = 1'b0;
  end
  // Released strobes change every cycle, so a stale level never qualifies.
  always @(negedge mclk_i) begin
    float_ff <= ~float_ff;
    if (hold_ff) begin
      ale_o <= 1'b0;
      program_store_strobe_n_o <= 1'b1;
    end else begin
      ale_o <= ~ale_o;
      program_store_strobe_n_o <= ~ale_o;
    end
  end
  // Top bits read 3 when forced low; otherwise they rest on the pullups in reset and wander.
  assign p2_top_o = p2_low_ff ? 3'h3 : (p2_pullup_i ? 3'h7 : float_ff);
  // Holds the reset pin high for a number of clocks.
  task automatic pin_reset(input int clks);
    @(negedge mclk_i) ext_rst_o <= 1'b1;
    repeat (clks) @(negedge mclk_i);
    ext_rst_o <= 1'b0;
  endtask : pin_reset
  // Raises the pin, sets strobes and top bits, releases, then holds.
  task automatic dis_seq(input int hold_clks, input logic strobes, input logic p2_low);
    @(negedge mclk_i) ext_rst_o <= 1'b1;
    hold_ff <= strobes;
    p2_low_ff <= p2_low;
    repeat (12) @(negedge mclk_i);
    ext_rst_o <= 1'b0;
    repeat (hold_clks) @(negedge mclk_i);
    hold_ff <= 1'b0;
    p2_low_ff <= 1'b0;
  endtask : dis_seq
endmodule : rstisd_board

/* File: dv/reset_state_and_isd_control_test.sv */
// Self-checking bench for the reset sequencer and disable mode.
`timescale 1ns/100ps
module reset_state_and_isd_control_test;
  typedef struct {int kind; int hold; int lo; int hi;} rstisd_row_t;
  localparam int MC = 4;
  localparam int WARM = 16;
  logic mclk_i, rst_n_i, por_i, stop_mode_i, ext_rst_i, wdt_timeout_i, osc_fail_i, osc_fail_detect_enable_i;
  logic ale_i, program_store_strobe_n_i, ram_wr_i, sp_wr_i, ie_wr_i, tmr_run_wr_i, wdt_sel_wr_i, port_wr_i;
  logic [2:0] p2_top_i;
  logic [7:0] sp_wdata_i, ie_wdata_i, port_wdata_i, sp_o, ie_o, port_latch_o;
  logic [1:0] tmr_run_wdata_i, wdt_sel_wdata_i, tmr_run_o, wdt_sel_o;
  logic reset_status_out_n_o, core_reset_o, exec_enable_o, osc_enable_o, ram_wr_en_o, port_weak_pullup_o;
  logic port_oe_n_o, ctrl_pins_oe_n_o, p2_top_pullup_o, test_mode_o, in_system_disable_o, fetch_start_o;
  logic [15:0] fetch_addr_o;
  int failures = 0;
  int n_checks = 0;
  // Kinds: 0 watchdog, 1 oscillator fail, 2 pin, 3 power-on, 4 pin in stop.
  rstisd_row_t rows [5] = '{'{0, 1, 8, 8}, '{1, 20, 18, 22}, '{2, 24, 14, 24}, '{3, 4, 16, 24}, '{4, 8, 19, 28}};

  rstisd_core #(.CLKS_PER_MC(MC), .WARM_CLKS(WARM)) i_dut (.mclk_i, .rst_n_i, .por_i, .stop_mode_i,
    .ext_rst_i, .wdt_timeout_i, .osc_fail_i, .osc_fail_detect_enable_i, .ale_i, .program_store_strobe_n_i,
    .p2_top_i, .ram_wr_i, .sp_wr_i, .sp_wdata_i, .ie_wr_i, .ie_wdata_i, .tmr_run_wr_i, .tmr_run_wdata_i,
    .wdt_sel_wr_i, .wdt_sel_wdata_i, .port_wr_i, .port_wdata_i, .reset_status_out_n_o, .core_reset_o,
    .exec_enable_o, .osc_enable_o, .ram_wr_en_o, .sp_o, .ie_o, .tmr_run_o, .wdt_sel_o, .port_latch_o,
    .port_weak_pullup_o, .port_oe_n_o, .ctrl_pins_oe_n_o, .p2_top_pullup_o, .test_mode_o,
    .in_system_disable_o, .fetch_start_o, .fetch_addr_o);
  rstisd_board i_board (.mclk_i, .p2_pullup_i(p2_top_pullup_o), .ext_rst_o(ext_rst_i), .ale_o(ale_i),
    .program_store_strobe_n_o(program_store_strobe_n_i), .p2_top_o(p2_top_i));

  // Clock at 200 MHz.
  always #2.5 mclk_i = ~mclk_i;

  // Compares a value and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Compares a cycle count against a window.
  task automatic chk_rng(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc
  // Loads non-default values so that a reset has something to undo.
  task automatic wr_regs;
    @(negedge mclk_i) {sp_wr_i, ie_wr_i, tmr_run_wr_i, wdt_sel_wr_i, port_wr_i} = 5'h1F;
    @(negedge mclk_i) {sp_wr_i, ie_wr_i, tmr_run_wr_i, wdt_sel_wr_i, port_wr_i} = 5'h00;
    chk(sp_o, 8'h5A);
    chk({ie_o, tmr_run_o, wdt_sel_o}, 12'hA5E);
    chk(port_latch_o, 8'h0F);
  endtask : wr_regs
  // State that must hold while in reset.
  task automatic rst_chk;
    chk({reset_status_out_n_o, core_reset_o}, 2'b01);
    chk({exec_enable_o, osc_enable_o, ram_wr_en_o}, 3'h2);
    chk(sp_o, 8'h07);
    chk({ie_o, tmr_run_o}, 10'h000);
    chk(wdt_sel_o, 2'h0);
    chk({port_latch_o, port_weak_pullup_o}, 9'h1FF);
    chk(p2_top_pullup_o, 1'b1);
  endtask : rst_chk
  // Times the low status span, then checks the restart.
  task automatic measure(input int lo, input int hi);
    int w, n;
    w = 0;
    n = 0;
    while (reset_status_out_n_o !== 1'b0 && w < 40) begin
      cyc(1);
      w++;
    end
    while (reset_status_out_n_o === 1'b0 && n < 300) begin
      if (n == 2) rst_chk();
      cyc(1);
      n++;
    end
    chk_rng(n, lo, hi);
    w = 0;
    while (fetch_start_o !== 1'b1 && w < 4) begin
      cyc(1);
      w++;
    end
    chk({fetch_start_o, fetch_addr_o}, 17'h10000);
    cyc(2);
    chk({exec_enable_o, ram_wr_en_o}, 2'h3);
  endtask : measure
  // Raises one reset source for the row's hold time.
  task automatic apply(input rstisd_row_t r);
    @(negedge mclk_i);
    case (r.kind)
      0: wdt_timeout_i = 1'b1;
      1: {osc_fail_detect_enable_i, osc_fail_i} = 2'b11;
      3: por_i = 1'b1;
      4: stop_mode_i = 1'b1;
      default: ;
    endcase
    if (r.kind == 2 || r.kind == 4) i_board.pin_reset(r.hold);
    else repeat (r.hold) @(negedge mclk_i);
    {wdt_timeout_i, osc_fail_i, osc_fail_detect_enable_i, por_i, stop_mode_i} = 5'h00;
  endtask : apply
  task automatic end_sim;
    $display("TB: checks=%0d errors=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // Main sequence: power-up, table rows, then the awkward cases.
  initial begin
    mclk_i = 1'b0;
    rst_n_i = 1'b0;
    {por_i, stop_mode_i, wdt_timeout_i, osc_fail_i, osc_fail_detect_enable_i} = 5'h00;
    {sp_wr_i, ie_wr_i, tmr_run_wr_i, wdt_sel_wr_i, port_wr_i} = 5'h00;
    ram_wr_i = 1'b1;
    sp_wdata_i = 8'h5A;
    ie_wdata_i = 8'hA5;
    tmr_run_wdata_i = 2'h3;
    wdt_sel_wdata_i = 2'h2;
    port_wdata_i = 8'h0F;
    repeat (2) @(negedge mclk_i);
    rst_n_i = 1'b1;
    measure(WARM, WARM + 4);
    foreach (rows[i]) begin
      wr_regs();
      fork
        apply(rows[i]);
        measure(rows[i].lo, rows[i].hi);
      join
    end
    // A failing oscillator is ignored while detection is off.
    @(negedge mclk_i) osc_fail_i = 1'b1;
    cyc(10);
    chk(reset_status_out_n_o, 1'b1);
    @(negedge mclk_i) osc_fail_i = 1'b0;
    // Disable entry, strobes ignored once on, pin reset leaves it.
    i_board.dis_seq(12, 1'b1, 1'b0);
    cyc(2);
    chk({in_system_disable_o, port_oe_n_o, ctrl_pins_oe_n_o, port_weak_pullup_o, p2_top_pullup_o}, 5'h1C);
    chk({reset_status_out_n_o, osc_enable_o, exec_enable_o}, 3'h6);
    cyc(10);
    chk(in_system_disable_o, 1'b1);
    fork
      i_board.pin_reset(12);
      measure(8, 8);
    join
    chk(in_system_disable_o, 1'b0);
    // Strobes dropped before two machine cycles abort entry.
    i_board.dis_seq(2, 1'b1, 1'b0);
    cyc(8);
    chk(in_system_disable_o, 1'b0);
    // Top bits count only at the pin's fall.
    i_board.dis_seq(8, 1'b0, 1'b1);
    cyc(2);
    chk(test_mode_o, 1'b1);
    cyc(20);
    chk(test_mode_o, 1'b1);
    i_board.dis_seq(8, 1'b0, 1'b0);
    cyc(2);
    chk(test_mode_o, 1'b0);
    // Second asynchronous reset in mid-run.
    @(negedge mclk_i) rst_n_i = 1'b0;
    #1 chk(reset_status_out_n_o, 1'b0);
    @(negedge mclk_i) rst_n_i = 1'b1;
    measure(WARM, WARM + 4);
    end_sim();
  end
  // Cuts a hang short.
  initial begin
    #20000;
    failures++;
    end_sim();
  end
endmodule : reset_state_and_isd_control_test
